/* channel_clock_divider_pair.sv */
`timescale 1ns/1ns
module channel_clock_divider_pair
   import clkdiv_pkg::*;
(
   input  wire logic              clk_i,             // system clock
   input  wire logic              rst_i,             // sync reset, high
   input  wire logic [ADDR_W-1:0] adr_i,             // wishbone byte addr
   input  wire logic [DATA_W-1:0] dat_i,             // wishbone write data
   input  wire logic              we_i,              // wishbone write
   input  wire logic [3:0]        sel_i,             // wishbone lanes
   input  wire logic              cyc_i,             // wishbone cycle
   input  wire logic              stb_i,             // wishbone strobe
   output logic [DATA_W-1:0]      dat_o,             // wishbone read data
   output logic                   ack_o,             // wishbone ack
   input  wire logic              osc_i,             // internal_oscillator
   input  wire logic              ext_clk_i,         // external clock in
   input  wire logic              sync_n_i,          // chip sync, low
   output logic                   pair0_output_a_o,  // pair 0 output a
   output logic                   pair0_output_b_o,  // pair 0 output b
   output logic                   pair1_output_a_o,  // pair 1 output a
   output logic                   pair1_output_b_o   // pair 1 output b
);

   // ==========================================================
   // pin synchronisers
   // one private pair of flops per pin: the first stage is read only
   // by the second, so no logic ever sees a metastable level
   localparam int NUM_PINS = 3;

   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_sync;
   logic                osc_s;
   logic                ext_s;
   logic                sync_s;

   // sync is inverted ahead of the flops so reset leaves it released
   assign pin_raw = {~sync_n_i, ext_clk_i, osc_i};

   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p++)
      begin : g_pin
         logic meta_q;
         logic sync_q;

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end
            else
            begin
               meta_q <= pin_raw[p];
               sync_q <= meta_q;
            end
         end

         assign pin_sync[p] = sync_q;
      end
   endgenerate

   assign osc_s  = pin_sync[0];
   assign ext_s  = pin_sync[1];
   assign sync_s = pin_sync[2];

   // ==========================================================
   // wishbone decode
   logic [IDX_W-1:0]  idx;
   logic              req;
   logic              wr_en;
   logic              hit_cfg;
   logic              hit_src;
   logic              hit_stat;
   logic [IDX_W-1:0]  slot_full;
   logic [SLOT_W-1:0] slot;

   assign idx       = adr_i[IDX_W+1:2];
   assign req       = cyc_i & stb_i & ~ack_o;
   assign wr_en     = req & we_i & sel_i[0];
   assign hit_cfg   = (idx >= IDX_DIV0_CYCLE_COUNTS)
                    & (idx <= IDX_DIV1_ROUTING_DCC);
   assign hit_src   = (idx == IDX_INPUT_SOURCE);
   assign hit_stat  = (idx == IDX_DIVIDER_STATUS);
   assign slot_full = idx - IDX_DIV0_CYCLE_COUNTS;
   assign slot      = slot_full[SLOT_W-1:0];

   // ==========================================================
   // register storage
   // every entry decodes its own enable; the read side is a one-hot
   // or-chain, so a slot past the table can neither write nor read
   logic [REG_W-1:0]        cfg_val [NUM_CFG_REGS];
   logic [REG_W-1:0]        cfg_chain [NUM_CFG_REGS];
   logic [NUM_CFG_REGS-1:0] cfg_sel;
   logic [REG_W-1:0]        cfg_rd;
   logic [1:0]              src_sel_q;

   genvar e;
   generate
      for (e = 0; e < NUM_CFG_REGS; e++)
      begin : g_entry
         logic [REG_W-1:0] ent_q;
         logic [REG_W-1:0] ent_rd;

         assign cfg_sel[e] = hit_cfg & (slot == SLOT_W'(e));
         assign cfg_val[e] = ent_q;
         assign ent_rd     = cfg_sel[e] ? ent_q : '0;

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               ent_q <= RST_CFG_REG;
            end
            else if (wr_en && cfg_sel[e])
            begin
               ent_q <= dat_i[REG_W-1:0];
            end
         end

         if (e == 0)
         begin : g_head
            assign cfg_chain[e] = ent_rd;
         end
         else
         begin : g_link
            assign cfg_chain[e] = cfg_chain[e-1] | ent_rd;
         end
      end
   endgenerate

   assign cfg_rd = cfg_chain[NUM_CFG_REGS-1];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         src_sel_q <= RST_INPUT_SRC;
      end
      else if (wr_en && hit_src)
      begin
         src_sel_q <= dat_i[SRC_MSB:0];
      end
   end

   // ==========================================================
   // divider input selection
   // the oscillator code feeds the oscillator, every other code the
   // external clock input
   logic src_is_osc;
   logic src_is_ext;
   logic div_src;

   assign src_is_osc = (src_sel_q == SRC_OSC);
   assign src_is_ext = (src_sel_q == SRC_EXT);
   assign div_src    = src_is_osc ? osc_s : ext_s;

   // ==========================================================
   // channels
   // a source edge reaches the pairs five clocks after the pin through the counter, four in bypass, three when routed direct; a
   // source must toggle slower than half the clock to be counted
   logic [NUM_DIV-1:0] pair_q;
   logic [NUM_DIV-1:0] pair_d;
   logic [NUM_DIV-1:0] div_out;

   genvar g;
   generate
      for (g = 0; g < NUM_DIV; g++)
      begin : g_chan
         div_cfg_t         cfg;
         logic [REG_W-1:0] r_cyc;
         logic [REG_W-1:0] r_ctl;
         logic [REG_W-1:0] r_rt;
         logic             route_osc;
         logic             route_ext;

         assign r_cyc = cfg_val[g*REGS_PER_DIV];
         assign r_ctl = cfg_val[g*REGS_PER_DIV+1];
         assign r_rt  = cfg_val[g*REGS_PER_DIV+2];

         assign cfg.low_cycles  = r_cyc[CYC_LOW_MSB:CYC_LOW_LSB];
         assign cfg.high_cycles = r_cyc[CYC_HIGH_MSB:CYC_HIGH_LSB];
         assign cfg.bypass      = r_ctl[CTL_BYPASS];
         assign cfg.nosync      = r_ctl[CTL_NOSYNC];
         assign cfg.force_high  = r_ctl[CTL_FORCE_HIGH];
         assign cfg.start_high  = r_ctl[CTL_START_HIGH];
         assign cfg.phase       = r_ctl[CTL_PHASE_MSB:CTL_PHASE_LSB];
         assign cfg.direct      = r_rt[RT_DIRECT];
         assign cfg.duty_correction_disable = r_rt[RT_DCC_DISABLE];

         channel_divider u_div
         (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .src_i  (div_src),
            .sync_i (sync_s),
            .cfg_i  (cfg),
            .div_o  (div_out[g])
         );

         // code 01b and the unlisted code leave the divider in place
         assign route_osc = cfg.direct & src_is_osc;
         assign route_ext = cfg.direct & src_is_ext;
         assign pair_d[g] = route_osc ? osc_s :
                            route_ext ? ext_s :
                                        div_out[g];
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pair_q <= '0;
      end
      else
      begin
         pair_q <= pair_d;
      end
   end

   // both legs of a pair carry the same level; the pad makes it
   // differential
   assign pair0_output_a_o = pair_q[0];
   assign pair0_output_b_o = pair_q[0];
   assign pair1_output_a_o = pair_q[1];
   assign pair1_output_b_o = pair_q[1];

   // ==========================================================
   // read mux and acknowledge
   logic [DATA_W-1:0] rd_data;
   logic [REG_W-1:0]  status;

   assign status = {5'h00, sync_s, pair_q};
   assign rd_data = hit_cfg  ? DATA_W'(cfg_rd) :
                    hit_src  ? DATA_W'(src_sel_q) :
                    hit_stat ? DATA_W'(status) :
                               '0;

   // unmapped addresses are acknowledged, read zero, ignore writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end
      else
      begin
         ack_o <= req;
         dat_o <= req ? rd_data : '0;
      end
   end

endmodule

/* clkdiv_pkg.sv */
package clkdiv_pkg;

   // ==========================================================
   // bus geometry
   localparam int          ADDR_W       = 12;
   localparam int          DATA_W       = 32;
   localparam int          IDX_W        = 10;
   localparam int          REG_W        = 8;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [9:0]  IDX_DIV0_CYCLE_COUNTS = 10'h190;
   localparam logic [9:0]  IDX_DIV0_CONTROL      = 10'h191;
   localparam logic [9:0]  IDX_DIV0_ROUTING_DCC  = 10'h192;
   localparam logic [9:0]  IDX_DIV1_CYCLE_COUNTS = 10'h193;
   localparam logic [9:0]  IDX_DIV1_CONTROL      = 10'h194;
   localparam logic [9:0]  IDX_DIV1_ROUTING_DCC  = 10'h195;
   localparam logic [9:0]  IDX_INPUT_SOURCE      = 10'h1e1;
   localparam logic [9:0]  IDX_DIVIDER_STATUS    = 10'h1e2;

   localparam int          NUM_DIV       = 2;
   localparam int          REGS_PER_DIV  = 3;
   localparam int          NUM_CFG_REGS  = 6;
   localparam int          SLOT_W        = 3;

   // ==========================================================
   // field positions
   localparam int          CYC_LOW_MSB    = 7;
   localparam int          CYC_LOW_LSB    = 4;
   localparam int          CYC_HIGH_MSB   = 3;
   localparam int          CYC_HIGH_LSB   = 0;
   localparam int          CTL_BYPASS     = 7;
   localparam int          CTL_NOSYNC     = 6;
   localparam int          CTL_FORCE_HIGH = 5;
   localparam int          CTL_START_HIGH = 4;
   localparam int          CTL_PHASE_MSB  = 3;
   localparam int          CTL_PHASE_LSB  = 0;
   localparam int          RT_DIRECT      = 1;
   localparam int          RT_DCC_DISABLE = 0;
   localparam int          SRC_MSB        = 1;
   localparam int          ST_LEVEL_LSB   = 0;
   localparam int          ST_SYNC        = 2;

   // input-source codes
   localparam logic [1:0]  SRC_OSC = 2'b10;
   localparam logic [1:0]  SRC_EXT = 2'b00;

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_CFG_REG    = 8'h00;
   localparam logic [1:0]  RST_INPUT_SRC  = 2'b00;

   // divider counter width: a full period reaches 32 input cycles
   localparam int          CNT_W = 6;

   // ==========================================================
   // types
   typedef struct packed {
      logic [3:0] low_cycles;
      logic [3:0] high_cycles;
      logic       bypass;
      logic       nosync;
      logic       force_high;
      logic       start_high;
      logic [3:0] phase;
      logic       direct;
      logic       duty_correction_disable;
   } div_cfg_t;

   typedef enum logic [1:0] {
      ST_HOLD  = 2'b00,
      ST_PHASE = 2'b01,
      ST_RUN   = 2'b11
   } div_state_t;

endpackage

/* channel_divider.sv */
`timescale 1ns/1ns
module channel_divider
   import clkdiv_pkg::*;
(
   input  wire logic     clk_i,   // system clock
   input  wire logic     rst_i,   // synchronous reset, high
   input  wire logic     src_i,   // synchronised divider input level
   input  wire logic     sync_i,  // chip-level sync asserted
   input  wire div_cfg_t cfg_i,   // channel configuration
   output logic          div_o    // divider output level
);

   // ==========================================================
   // half-period lengths
   logic [CNT_W-1:0] total_len;
   logic [CNT_W-1:0] hi_len;
   logic [CNT_W-1:0] lo_len;
   logic [CNT_W-1:0] hi_dcc;
   logic             src_q;
   logic             src_edge;
   logic             hold;
   logic             forced;

   assign total_len = CNT_W'(cfg_i.low_cycles) + CNT_W'(cfg_i.high_cycles)
                    + CNT_W'(2);
   // correction splits the period evenly; an odd period gets the
   // extra input cycle on the high side
   assign hi_dcc    = CNT_W'((total_len + CNT_W'(1)) >> 1);
   assign hi_len    = cfg_i.duty_correction_disable ?
                      CNT_W'(cfg_i.high_cycles) + CNT_W'(1) : hi_dcc;
   assign lo_len    = cfg_i.duty_correction_disable ?
                      CNT_W'(cfg_i.low_cycles) + CNT_W'(1) :
                      total_len - hi_dcc;
   assign src_edge  = src_i & ~src_q;
   assign hold      = sync_i & ~cfg_i.nosync;
   assign forced    = sync_i & cfg_i.nosync;

   // ==========================================================
   // counter state machine
   div_state_t       state_q;
   div_state_t       state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             lvl_q;
   logic             lvl_d;
   logic             out_d;

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      lvl_d   = lvl_q;
      if (hold || cfg_i.bypass)
      begin
         // bypass powers the counter down; both restart from phase
         state_d = ST_HOLD;
         lvl_d   = cfg_i.start_high;
         cnt_d   = '0;
      end
      else
      begin
         case (state_q)
            ST_HOLD:
            begin
               lvl_d = cfg_i.start_high;
               if (cfg_i.phase != 4'h0)
               begin
                  state_d = ST_PHASE;
                  cnt_d   = CNT_W'(cfg_i.phase);
               end
               else
               begin
                  state_d = ST_RUN;
                  cnt_d   = cfg_i.start_high ? hi_len : lo_len;
               end
            end
            ST_PHASE:
            begin
               if (src_edge)
               begin
                  if (cnt_q <= CNT_W'(1))
                  begin
                     state_d = ST_RUN;
                     cnt_d   = lvl_q ? hi_len : lo_len;
                  end
                  else
                  begin
                     cnt_d = cnt_q - CNT_W'(1);
                  end
               end
            end
            ST_RUN:
            begin
               if (src_edge)
               begin
                  if (cnt_q <= CNT_W'(1))
                  begin
                     lvl_d = ~lvl_q;
                     cnt_d = lvl_q ? lo_len : hi_len;
                  end
                  else
                  begin
                     cnt_d = cnt_q - CNT_W'(1);
                  end
               end
            end
            default:
            begin
               state_d = ST_HOLD;
            end
         endcase
      end
   end

   assign out_d = cfg_i.bypass ? src_i :
                  forced       ? cfg_i.force_high : lvl_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_HOLD;
         cnt_q   <= '0;
         lvl_q   <= 1'b0;
         src_q   <= 1'b0;
         div_o   <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         lvl_q   <= lvl_d;
         src_q   <= src_i;
         div_o   <= out_d;
      end
   end

endmodule

/* clkdiv_pair_checker.sv */
`timescale 1ns/1ns
module clkdiv_pair_checker
   import clkdiv_pkg::*;
(
   input wire logic              clk_i,            // clock
   input wire logic              rst_i,            // reset
   input wire logic [ADDR_W-1:0] adr_i,            // address
   input wire logic [DATA_W-1:0] dat_i,            // write data
   input wire logic              we_i,             // write
   input wire logic [3:0]        sel_i,            // lanes
   input wire logic              cyc_i,            // cycle
   input wire logic              stb_i,            // strobe
   input wire logic [DATA_W-1:0] dat_o,            // read data
   input wire logic              ack_o,            // ack
   input wire logic              osc_i,            // oscillator
   input wire logic              ext_clk_i,        // clock input
   input wire logic              sync_n_i,         // sync, low
   input wire logic              pair0_output_a_o, // pair 0 a
   input wire logic              pair0_output_b_o, // pair 0 b
   input wire logic              pair1_output_a_o, // pair 1 a
   input wire logic              pair1_output_b_o  // pair 1 b
);
   // ==========================================================
   // shadow of divider 0 setup, taken at the acking edge
   logic [7:0] ctl0_q;
   logic [7:0] rt0_q;
   logic       rst_seen_q;
   wire        wr_hit = ack_o && we_i && sel_i[0];
   always_ff @(posedge clk_i)
      rst_seen_q <= rst_i;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctl0_q <= 8'h00;
         rt0_q  <= 8'h00;
      end
      else if (wr_hit && adr_i[11:2] == IDX_DIV0_CONTROL)
         ctl0_q <= dat_i[7:0];
      else if (wr_hit && adr_i[11:2] == IDX_DIV0_ROUTING_DCC)
         rt0_q <= dat_i[7:0];
   end
   // ==========================================================
   // properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence sync_held;
      (!sync_n_i) [*8];
   endsequence
   sequence req_new;
      cyc_i && stb_i && !ack_o;
   endsequence
   ack_once_a: assert property (req_new |=> ack_o)
      else $error("request not acked after one cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   unmapped_rd_a: assert property (ack_o && !we_i
      && adr_i[11:2] > IDX_DIVIDER_STATUS |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   pair0_same_a: assert property (pair0_output_a_o == pair0_output_b_o)
      else $error("pair 0 outputs differ");
   pair1_same_a: assert property (pair1_output_a_o == pair1_output_b_o)
      else $error("pair 1 outputs differ");
   reset_low_a: assert property (rst_seen_q |-> !ack_o
      && !pair0_output_a_o && !pair1_output_a_o)
      else $error("outputs not low after reset");
   start_hold_a: assert property (sync_held ##0
      (ctl0_q[7:6] == 2'b00 && !rt0_q[RT_DIRECT])
      |-> pair0_output_a_o == ctl0_q[CTL_START_HIGH])
      else $error("held divider not at start level");
   force_lvl_a: assert property (sync_held ##0
      (ctl0_q[7:6] == 2'b01 && !rt0_q[RT_DIRECT])
      |-> pair0_output_a_o == ctl0_q[CTL_FORCE_HIGH])
      else $error("forced level wrong");
endmodule
bind channel_clock_divider_pair clkdiv_pair_checker i_chk (.*);

/* clock_load_monitor.sv */
`timescale 1ns/1ns
module clock_load_monitor
(
   input  wire logic  clk_i,    // system clock
   input  wire logic  rst_i,    // sync reset
   input  wire logic  lvl_i,    // observed clock level
   output logic [7:0] hi_len_o, // last high run
   output logic [7:0] lo_len_o  // last low run
);
   // ==========================================================
   // run lengths; saturates so a static level never wraps
   logic       prev_q;
   logic [7:0] run_q;
   always_ff @(posedge clk_i)
   begin
      prev_q <= lvl_i;
      if (rst_i)
      begin
         run_q    <= 8'h00;
         hi_len_o <= 8'h00;
         lo_len_o <= 8'h00;
      end
      else if (lvl_i != prev_q)
      begin
         run_q <= 8'h01;
         if (prev_q)
            hi_len_o <= run_q;
         else
            lo_len_o <= run_q;
      end
      else if (run_q != 8'hff)
         run_q <= run_q + 8'h01;
   end
endmodule

/* channel_clock_divider_pair_test.sv */
`timescale 1ns/1ns
module channel_clock_divider_pair_test
   import clkdiv_pkg::*;
;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [ADDR_W-1:0] adr_i = 12'h000;
   logic [DATA_W-1:0] dat_i = 32'h0;
   logic              we_i = 1'b0;
   logic [3:0]        sel_i = 4'h0;
   logic              cyc_i = 1'b0;
   logic              stb_i = 1'b0;
   logic              osc_i = 1'b0;
   logic              ext_clk_i = 1'b0;
   logic              sync_n_i = 1'b1;
   logic [DATA_W-1:0] dat_o;
   logic              ack_o;
   logic              pair0_output_a_o;
   logic              pair0_output_b_o;
   logic              pair1_output_a_o;
   logic              pair1_output_b_o;
   logic [7:0]        hi0, lo0, hi1, lo1;
   logic [7:0]        tick = 8'h00;
   logic [1:0]        e3 = 2'h0;
   int                err_total = 0;
   int                cmp_count = 0;
   int                cyc_cnt = 0;
   int                c0, c3;

   channel_clock_divider_pair i_dut (.*);
   clock_load_monitor i_load0 (.clk_i(clk_i), .rst_i(rst_i),
      .lvl_i(pair0_output_a_o), .hi_len_o(hi0), .lo_len_o(lo0));
   clock_load_monitor i_load1 (.clk_i(clk_i), .rst_i(rst_i),
      .lvl_i(pair1_output_b_o), .hi_len_o(hi1), .lo_len_o(lo1));

   // ==========================================================
   // clocks: oscillator period 4 cycles, clock input period 6
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      tick <= tick + 8'h01;
      osc_i <= tick[1];
      e3 <= (e3 == 2'h2) ? 2'h0 : e3 + 2'h1;
      if (e3 == 2'h2)
         ext_clk_i <= ~ext_clk_i;
      cyc_cnt++;
      if (cyc_cnt == 10000)
      begin
         err_total++;
         complete_run();
      end
   end

   // ==========================================================
   // helpers
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [9:0] idx,
      input logic [7:0] d, input logic [3:0] s, output logic [31:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      sel_i <= s;
      do
      begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, idx, d, 4'h1, q);
   endtask
   task automatic rc(input logic [9:0] idx, input logic [7:0] e);
      logic [31:0] q;
      wb(1'b0, idx, 8'h00, 4'h1, q);
      chk(q, {24'h0, e});
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      logic [31:0] q;
      logic [9:0]  a;
      for (int i = 0; i < NUM_CFG_REGS; i++)
      begin
         a = IDX_DIV0_CYCLE_COUNTS + 10'(i);
         rc(a, 8'h00);
         wr(a, 8'h5a + 8'(i));
         wb(1'b1, a, 8'hff, 4'h0, q);
         rc(a, 8'h5a + 8'(i));
         wr(a, 8'h00);
      end
      rc(10'h1f0, 8'h00);
      wr(IDX_INPUT_SOURCE, 8'hff);
      rc(IDX_INPUT_SOURCE, 8'h03);
      wr(IDX_INPUT_SOURCE, 8'h00);
      rc(IDX_INPUT_SOURCE, 8'h00);
   endtask
   // divider test; the reset source is the 6-cycle clock input
   task automatic t_div(input logic ch, input logic [7:0] cv,
      input logic dcc, input logic [7:0] eh, input logic [7:0] el);
      wr(ch ? IDX_DIV1_CYCLE_COUNTS : IDX_DIV0_CYCLE_COUNTS, cv);
      wr(ch ? IDX_DIV1_ROUTING_DCC : IDX_DIV0_ROUTING_DCC, {7'h0, dcc});
      repeat (200) @(posedge clk_i);
      chk(ch ? hi1 : hi0, eh);
      chk(ch ? lo1 : lo0, el);
   endtask
   task automatic t_route(input logic [7:0] ctl, input logic [7:0] rt,
      input logic [7:0] src, input logic [7:0] eh, input logic [7:0] el);
      wr(IDX_DIV0_CONTROL, ctl);
      wr(IDX_DIV0_ROUTING_DCC, rt);
      wr(IDX_INPUT_SOURCE, src);
      repeat (200) @(posedge clk_i);
      chk(hi0, eh);
      chk(lo0, el);
   endtask
   // hold under sync, then release on an oscillator boundary and
   // count cycles to the first level change
   task automatic t_sync(input logic [7:0] ctl, input logic e,
      output int c);
      wr(IDX_DIV0_CONTROL, ctl);
      sync_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk(pair0_output_a_o, e);
      rc(IDX_DIVIDER_STATUS, {5'h00, 1'b1, 1'b0, e});
      while (tick[1:0] != 2'h0)
         @(posedge clk_i);
      sync_n_i <= 1'b1;
      c = 0;
      while (pair0_output_a_o === e && c < 300)
      begin
         @(posedge clk_i);
         c++;
      end
      repeat (20) @(posedge clk_i);
   endtask

   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_div(1'b0, 8'h21, 1'b1, 8'd12, 8'd18);
      t_div(1'b1, 8'h13, 1'b1, 8'd24, 8'd12);
      t_div(1'b0, 8'h21, 1'b0, 8'd18, 8'd12);
      t_div(1'b1, 8'h02, 1'b0, 8'd12, 8'd12);
      t_route(8'h80, 8'h01, 8'h02, 8'd2, 8'd2);
      t_route(8'h00, 8'h03, 8'h00, 8'd3, 8'd3);
      t_route(8'h00, 8'h03, 8'h02, 8'd2, 8'd2);
      t_route(8'h00, 8'h03, 8'h01, 8'd12, 8'd18);
      t_route(8'h00, 8'h03, 8'h03, 8'd12, 8'd18);
      t_route(8'h00, 8'h01, 8'h01, 8'd12, 8'd18);
      wr(IDX_INPUT_SOURCE, 8'h02);
      t_sync(8'h10, 1'b1, c0);
      t_sync(8'h60, 1'b1, c0);
      t_sync(8'h40, 1'b0, c0);
      t_sync(8'h00, 1'b0, c0);
      t_sync(8'h03, 1'b0, c3);
      chk(32'(c3 - c0), 32'd12);
      complete_run();
   end
endmodule
